// File: status_pkg.sv
package status_pkg;

  localparam int STB_MSB_BIT = 0;
  localparam int STB_MSG_BIT = 2;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_RQS_BIT = 6;

  localparam int ESR_OPC_BIT = 0;
  localparam int ESR_RQC_BIT = 1;
  localparam int ESR_QYE_BIT = 2;
  localparam int ESR_DDE_BIT = 3;
  localparam int ESR_EXE_BIT = 4;
  localparam int ESR_CME_BIT = 5;
  localparam int ESR_URQ_BIT = 6;
  localparam int ESR_PON_BIT = 7;

  localparam logic [7:0] SRE_RESET      = 8'h00;
  localparam logic [7:0] ESE_RESET      = 8'h00;
  localparam logic [7:0] ESR_RESET      = 8'h80;
  localparam logic [7:0] SRE_WRITE_MASK = 8'hBF;
  localparam logic [7:0] ESR_READ_MASK  = 8'hBD;

  localparam int ERR_DEPTH = 8;
  localparam int ERR_WIDTH = 16;

  // Error sources seen by the parser and execution units.
  typedef struct packed {
    logic cmd_err;
    logic exe_err;
    logic dev_err;
    logic qry_err;
  } err_events_t;

  typedef struct packed {
    logic       wr_sre;
    logic       wr_ese;
    logic [7:0] wdata;
    logic       rd_esr;
    logic       clear_status;
    logic       after_term;
    logic       opc_cmd;
  } cmd_t;

endpackage

// File: error_queue.sv
`timescale 1ns/100ps
module error_queue #(
  parameter int DEPTH = status_pkg::ERR_DEPTH,
  parameter int WIDTH = status_pkg::ERR_WIDTH
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_clear,
  input  wire logic             i_push,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_pop,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_not_empty,
  output logic                  o_overflow
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             full;
  logic             do_push;
  logic             do_pop;

  assign full        = (cnt_q == (AW+1)'(DEPTH));
  assign o_not_empty = (cnt_q != '0);
  assign do_pop      = i_pop && o_not_empty;
  // A full queue drops new entries and flags it, unless a pop comes in the same cycle; old errors matter most.
  assign do_push     = i_push && (!full || do_pop);
  assign o_data      = mem[rd_q];

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge i_clk_sys) begin
    if (do_push) begin
      mem[wr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_clear) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= inc(wr_q);
      end
      if (do_pop) begin
        rd_q <= inc(rd_q);
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_clear) begin
      o_overflow <= 1'b0;
    end else if (i_push && full && !do_pop) begin
      o_overflow <= 1'b1;
    end
  end
endmodule

// File: ieee488_status_reporting.sv
`timescale 1ns/100ps
module ieee488_status_reporting #(
  parameter int ERR_DEPTH = status_pkg::ERR_DEPTH,
  parameter int ERR_WIDTH = status_pkg::ERR_WIDTH
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst,
  input  wire status_pkg::cmd_t      i_cmd,
  input  wire status_pkg::err_events_t i_err,
  input  wire logic [ERR_WIDTH-1:0]  i_err_code,
  input  wire logic                  i_err_pop,
  input  wire logic                  i_ops_pending,
  input  wire logic                  i_remote_to_local_flag,
  input  wire logic                  i_module_summary,
  input  wire logic                  i_out_queue_not_empty,
  input  wire logic                  i_msg_queue_not_empty,
  input  wire logic                  i_serial_poll,
  output logic                       o_out_queue_clear,
  output logic [7:0]                 o_sre,
  output logic [7:0]                 o_ese,
  output logic [7:0]                 o_esr,
  output logic [7:0]                 o_stb,
  output logic [7:0]                 o_poll_byte,
  output logic                       o_srq,
  output logic [ERR_WIDTH-1:0]       o_err_code,
  output logic                       o_err_not_empty,
  output logic                       o_err_overflow
);

  logic [7:0] sre_q;
  logic [7:0] ese_q;
  logic [7:0] esr_q;
  logic [7:0] esr_set;
  logic [7:0] summary;
  logic       mss;
  logic       rqs_q;
  logic       mss_q;
  logic       opc_armed_q;
  logic       any_err;
  logic       clr;

  assign clr     = i_cmd.clear_status;
  assign any_err = i_err.cmd_err | i_err.exe_err | i_err.dev_err
                 | i_err.qry_err;

  // Service request enable register; bit six is never stored.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sre_q <= status_pkg::SRE_RESET;
    end else if (i_cmd.wr_sre) begin
      sre_q <= i_cmd.wdata & status_pkg::SRE_WRITE_MASK;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ese_q <= status_pkg::ESE_RESET;
    end else if (i_cmd.wr_ese) begin
      ese_q <= i_cmd.wdata;
    end
  end

  // Completion waits until every pending operation has drained.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || clr) begin
      opc_armed_q <= 1'b0;
    end else if (i_cmd.opc_cmd) begin
      opc_armed_q <= 1'b1;
    end else if (!i_ops_pending) begin
      opc_armed_q <= 1'b0;
    end
  end

  always_comb begin
    esr_set = 8'h00;
    esr_set[status_pkg::ESR_OPC_BIT] = opc_armed_q && !i_ops_pending;
    esr_set[status_pkg::ESR_QYE_BIT] = i_err.qry_err;
    esr_set[status_pkg::ESR_DDE_BIT] = i_err.dev_err;
    esr_set[status_pkg::ESR_EXE_BIT] = i_err.exe_err;
    esr_set[status_pkg::ESR_CME_BIT] = i_err.cmd_err;
    // Bit one of this register carries the remote to local event; bit six stays 0.
    esr_set[status_pkg::ESR_URQ_BIT] = 1'b0;
    esr_set[status_pkg::ESR_RQC_BIT] = i_remote_to_local_flag;
  end

  // Event bits latch; a new event in the clearing cycle survives.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      esr_q <= status_pkg::ESR_RESET;
    end else if (clr || i_cmd.rd_esr) begin
      esr_q <= esr_set;
    end else begin
      esr_q <= esr_q | esr_set;
    end
  end

  always_comb begin
    summary = 8'h00;
    summary[status_pkg::STB_MSB_BIT] = i_module_summary;
    summary[status_pkg::STB_MSG_BIT] = i_msg_queue_not_empty;
    summary[status_pkg::STB_MAV_BIT] = i_out_queue_not_empty;
    summary[status_pkg::STB_ESB_BIT] = |(esr_q & ese_q);
  end

  assign mss = |(summary & sre_q & status_pkg::SRE_WRITE_MASK);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mss_q <= 1'b0;
    end else begin
      mss_q <= mss;
    end
  end

  // The request flag rises on a new reason and falls when polled or on a clear status.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || clr) begin
      rqs_q <= 1'b0;
    end else if (mss && !mss_q) begin
      rqs_q <= 1'b1;
    end else if (i_serial_poll) begin
      rqs_q <= 1'b0;
    end
  end

  error_queue #(
    .DEPTH (ERR_DEPTH),
    .WIDTH (ERR_WIDTH)
  ) u_errq (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_clear     (clr),
    .i_push      (any_err),
    .i_data      (i_err_code),
    .i_pop       (i_err_pop),
    .o_data      (o_err_code),
    .o_not_empty (o_err_not_empty),
    .o_overflow  (o_err_overflow)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_stb       <= 8'h00;
      o_poll_byte <= 8'h00;
      o_srq       <= 1'b0;
      o_esr       <= 8'h00;
      o_sre       <= 8'h00;
      o_ese       <= 8'h00;
      o_out_queue_clear <= 1'b0;
    end else begin
      o_stb       <= summary | (8'(mss) << status_pkg::STB_RQS_BIT);
      o_poll_byte <= summary | (8'(rqs_q) << status_pkg::STB_RQS_BIT);
      o_srq       <= rqs_q;
      // The remote to local event stays internal so the RQC slot reads 0.
      o_esr       <= esr_q & status_pkg::ESR_READ_MASK;
      o_sre       <= sre_q;
      o_ese       <= ese_q;
      o_out_queue_clear <= clr && i_cmd.after_term;
    end
  end

  srq_follow_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !rqs_q ##1 rqs_q |-> $past(mss) && !$past(mss_q))
    else $error("request flag rose without new reason");
  poll_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    rqs_q && i_serial_poll && !(mss && !mss_q) |=> !rqs_q)
    else $error("request flag not cleared by poll");
  sre_bit6_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !sre_q[6])
    else $error("enable bit six stored");
  esr_latch_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    esr_q[status_pkg::ESR_CME_BIT] && !clr && !i_cmd.rd_esr
    |=> esr_q[status_pkg::ESR_CME_BIT])
    else $error("event bit lost");
  cme_set_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_err.cmd_err |=> esr_q[status_pkg::ESR_CME_BIT])
    else $error("command error not latched");
  mav_track_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    1'b1 |=> o_stb[status_pkg::STB_MAV_BIT] == $past(i_out_queue_not_empty))
    else $error("message available wrong");
  esb_track_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    |(esr_q & ese_q) |=> o_stb[status_pkg::STB_ESB_BIT])
    else $error("event summary missing");
  r2l_latch_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_remote_to_local_flag |=> esr_q[status_pkg::ESR_RQC_BIT])
    else $error("remote to local event not latched");
  urq_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !o_esr[status_pkg::ESR_URQ_BIT])
    else $error("user request bit set");
  outq_clr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    clr && !i_cmd.after_term |=> !o_out_queue_clear)
    else $error("output queue cleared in general case");

  srq_cov: cover property (@(posedge i_clk_sys) rqs_q ##1 !rqs_q);
  opc_cov: cover property (@(posedge i_clk_sys)
    i_cmd.opc_cmd ##[1:20] esr_q[status_pkg::ESR_OPC_BIT]);
  cls_cov: cover property (@(posedge i_clk_sys) clr && i_cmd.after_term);
endmodule

// File: bus_ctrl_model.sv
`timescale 1ns/100ps
// Polls the device once per enable while its service request is up.
module bus_ctrl_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_en,
  input  wire logic       i_srq,
  input  wire logic [7:0] i_poll_byte,
  output logic            o_serial_poll,
  output logic [7:0]      o_poll_seen,
  output logic            o_done
);
  initial begin
    o_serial_poll = 1'b0;
    o_poll_seen   = 8'h00;
    o_done        = 1'b0;
  end
  always @(posedge i_clk_sys) begin
    if (o_serial_poll) begin
      o_poll_seen   <= i_poll_byte;
      o_serial_poll <= 1'b0;
      o_done        <= 1'b1;
    end else if (!i_en) begin
      o_done <= 1'b0;
    end else if (i_srq && !o_done) begin
      o_serial_poll <= 1'b1;
    end
  end
endmodule

// File: testbench.sv
`timescale 1ns/100ps
module testbench;
  logic                    clk_sys = 1'b0;
  logic                    rst = 1'b1;
  status_pkg::cmd_t        cmd = '0;
  status_pkg::err_events_t err = '0;
  logic [15:0]             code = 16'h1234;
  logic [15:0]             e_code;
  logic                    pop = 0, pend = 0, r2l = 0, msb = 0;
  logic                    oq = 0, mq = 0, poll_en = 0;
  logic                    poll, pdone, oqc, srq, ene, ovf;
  logic [7:0]              sre, ese, esr, stb, pbyte, pseen;
  int                      num_errors = 0;
  int                      n_compared = 0;

  ieee488_status_reporting uut (.i_clk_sys(clk_sys), .i_rst(rst),
    .i_cmd(cmd), .i_err(err), .i_err_code(code), .i_err_pop(pop),
    .i_ops_pending(pend), .i_remote_to_local_flag(r2l),
    .i_module_summary(msb), .i_out_queue_not_empty(oq),
    .i_msg_queue_not_empty(mq), .i_serial_poll(poll),
    .o_out_queue_clear(oqc), .o_sre(sre), .o_ese(ese), .o_esr(esr),
    .o_stb(stb), .o_poll_byte(pbyte), .o_srq(srq),
    .o_err_code(e_code), .o_err_not_empty(ene), .o_err_overflow(ovf));
  bus_ctrl_model ctrl (.i_clk_sys(clk_sys), .i_en(poll_en), .i_srq(srq),
    .i_poll_byte(pbyte), .o_serial_poll(poll), .o_poll_seen(pseen),
    .o_done(pdone));

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys) #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Holds the bench up to 8 cycles for cond, counting a mismatch if it does not come.
  task automatic wait_for(input string nm, ref logic cond);
    int i;
    for (i = 0; i < 8 && cond !== 1'b1; i++) tick(1);
    chk(nm, 1, cond);
  endtask
  task automatic write_enables();
    cmd.wr_sre = 1; cmd.wdata = 8'hFF; tick(1);
    cmd.wr_sre = 0; tick(1);
    chk("sre", 8'hBF, sre);
    cmd.wr_sre = 1; cmd.wdata = 8'h20; cmd.wr_ese = 1; tick(1);
    cmd.wdata = 8'h01; cmd.wr_sre = 0; tick(1);
    cmd.wr_ese = 0; tick(1);
    chk("sre", 8'h20, sre);
    chk("ese", 8'h01, ese);
  endtask
  task automatic error_events();
    err = 4'hF; tick(1);
    err = 0; tick(2);
    chk("esr", 8'hBC, esr);
    chk("err", 16'h1234, e_code);
    chk("urq", 0, esr[6]);
    cmd.rd_esr = 1; tick(1);
    cmd.rd_esr = 0; tick(2);
    chk("esr", 8'h00, esr);
    chk("err ne", 1, ene);
    pop = 1; tick(4);
    pop = 0; tick(1);
    chk("err ne", 0, ene);
  endtask
  task automatic completion_poll();
    pend = 1; cmd.opc_cmd = 1; tick(1);
    cmd.opc_cmd = 0; tick(3);
    chk("opc", 0, esr[0]);
    pend = 0;
    wait_for("srq", srq);
    chk("esb", 1, stb[5]);
    chk("mss", 1, stb[6]);
    poll_en = 1;
    wait_for("poll", pdone);
    poll_en = 0;
    chk("rqs", 1, pseen[6]);
    tick(3);
    chk("srq", 0, srq);
    chk("stb", 8'h60, stb);
    chk("pbyte", 8'h20, pbyte);
  endtask
  task automatic summaries_clear();
    oq = 1; mq = 1; msb = 1; tick(3);
    chk("stb", 8'h75, stb);
    oq = 0; mq = 0; msb = 0;
    r2l = 1; tick(1);
    r2l = 0; tick(1);
    chk("rqc", 0, esr[1]);
    cmd.clear_status = 1; tick(1);
    cmd.clear_status = 0; tick(1);
    chk("oqc", 0, oqc);
    tick(1);
    chk("esr", 8'h00, esr);
    chk("stb", 8'h00, stb);
    cmd.clear_status = 1; cmd.after_term = 1; tick(1);
    cmd.clear_status = 0; cmd.after_term = 0;
    wait_for("oqc", oqc);
    tick(1);
    chk("oqc", 0, oqc);
  endtask
  initial begin
    tick(6);
    rst = 0; tick(2);
    chk("esr", 8'h80, esr);
    chk("sre", 8'h00, sre);
    write_enables();
    error_events();
    completion_poll();
    summaries_clear();
    give_verdict();
  end
endmodule
